// ==== pus_pkg.sv ====
// shared constants and types for the power-up init sequencer
package pus_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OSC_SETTLE_US = 100;
  localparam int unsigned OSC_SETTLE_CYC =
    (OSC_SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
    OSC_SETTLE_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned STORE_DEPTH = 16;
  localparam int unsigned STORE_AW = 4;
  localparam logic [7:0] VCODE_BASE = 8'h77;
  localparam logic [7:0] VCODE_LAST = 8'h7E;
  localparam logic [6:0] BASE_ADDR_RST = 7'h10;
  localparam logic [9:0] ADC_STEP = 10'h040;
  localparam logic [3:0] OFFSET_MAX = 4'hF;
  localparam logic [10:0] FSW_MIN_KHZ = 11'h096;
  localparam logic [10:0] FSW_MAX_KHZ = 11'h5DC;
  localparam logic [1:0] EN_PIN = 2'h0;
  localparam logic [1:0] EN_SW_ONLY = 2'h1;
  localparam logic [1:0] EN_PIN_AND_SW = 2'h2;
  localparam logic [1:0] EN_ALWAYS = 2'h3;

  typedef struct packed {
    logic bias_ok;
    logic core_ok;
    logic osc_ok;
  } pus_rails_type;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } pus_cfg_wr_type;

  typedef enum logic [2:0] {
    ST_RESET, ST_LOAD, ST_ADDR, ST_IDLE, ST_RUN
  } pus_state_type;
endpackage

// ==== pus_sync.sv ====
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pus_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = i_ce ? i_d : meta_reg;
    q_next = i_ce ? meta_reg : o_q;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= meta_next;
      o_q <= q_next;
    end
  end
endmodule

// ==== pus_top.sv ====
// power-up init sequencer: reset hold, config load, address, enable gate
`timescale 1ns/1ps
module pus_top
  import pus_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = OSC_SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire pus_rails_type i_rails,
  input wire logic i_enable,
  input wire logic i_vin_ok,
  input wire logic [2:0] i_volt_select,
  input wire logic [9:0] i_addr_adc,
  input wire logic i_addr_adc_valid,
  input wire logic [7:0] i_store_data,
  input wire pus_cfg_wr_type i_cfg_wr,
  input wire logic [1:0] i_en_mode,
  input wire logic i_sw_on,
  input wire logic [10:0] i_fsw_khz,
  input wire logic i_fsw_wr,
  input wire logic i_no_addr_offset,
  output logic o_por_n,
  output logic [STORE_AW-1:0] o_store_addr,
  output logic o_load_done,
  output logic o_addr_done,
  output logic [6:0] o_dev_addr,
  output logic [7:0] o_vcode,
  output logic [7:0] o_vcode_reg_addr,
  output logic [10:0] o_fsw_khz,
  output logic o_cfg_wr_ack,
  output logic o_convert
);
  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [5:0] sync_q;
  logic [2:0] sel_q;
  logic en_s, vin_s, adcv_s;
  pus_rails_type rails_s;

  pus_sync #(.W(6)) u_sync_lvl (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_d({i_rails, i_enable, i_vin_ok, i_addr_adc_valid}),
    .o_q(sync_q)
  );
  pus_sync #(.W(3)) u_sync_sel (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_d(i_volt_select),
    .o_q(sel_q)
  );
  assign rails_s = sync_q[5:3];
  assign en_s = sync_q[2];
  assign vin_s = sync_q[1];
  assign adcv_s = sync_q[0];

  ////////////////////////////////////////////////////////////////
  // sequencer
  pus_state_type state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [STORE_AW-1:0] addr_reg, addr_next;
  logic load_reg, load_next;
  logic [7:0] work_reg [STORE_DEPTH];
  logic [6:0] dev_reg, dev_next;
  logic adone_reg, adone_next;
  logic [10:0] fsw_reg, fsw_next;
  logic conv_reg, conv_next;
  logic rails_ok, gate_ok, pin_ok;
  logic [3:0] ofs;
  logic cfg_hit;
  logic [7:0] vaddr;

  assign rails_ok = rails_s.bias_ok & rails_s.core_ok & rails_s.osc_ok;
  assign pin_ok = en_s & vin_s;
  // adc span divided into sixteen equal bands, top band saturates
  assign ofs = (i_addr_adc / ADC_STEP > 10'(OFFSET_MAX)) ? OFFSET_MAX :
               4'(i_addr_adc / ADC_STEP);
  // software modes drop or add to the enable pin term; i_vin_ok, load/address still needed
  always_comb begin
    case (i_en_mode)
      EN_PIN: gate_ok = pin_ok;
      EN_SW_ONLY: gate_ok = i_sw_on & vin_s;
      EN_PIN_AND_SW: gate_ok = pin_ok & i_sw_on;
      EN_ALWAYS: gate_ok = vin_s;
      default: gate_ok = pin_ok;
    endcase
  end
  // no acknowledge while frozen: the write would not land
  assign cfg_hit = i_ce && i_cfg_wr.wr && load_reg &&
                   i_cfg_wr.addr >= VCODE_BASE &&
                   i_cfg_wr.addr <= VCODE_LAST;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    load_next = load_reg;
    dev_next = dev_reg;
    adone_next = adone_reg;
    conv_next = 1'b0;
    case (state_reg)
      ST_RESET: begin
        load_next = 1'b0;
        adone_next = 1'b0;
        // settle count restarts on any dropout
        if (!rails_ok) cnt_next = '0;
        else if (cnt_reg >= SETTLE_CYC - 1) begin
          state_next = ST_LOAD;
          addr_next = '0;
        end else cnt_next = cnt_reg + 32'h1;
      end
      ST_LOAD: begin
        addr_next = addr_reg + STORE_AW'(1);
        if (addr_reg == STORE_AW'(STORE_DEPTH - 1)) begin
          load_next = 1'b1;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (adcv_s) begin
          dev_next = i_no_addr_offset ? BASE_ADDR_RST :
                     BASE_ADDR_RST + 7'(ofs);
          adone_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (gate_ok && load_reg && adone_reg) begin
          conv_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        conv_next = gate_ok;
        if (!gate_ok) state_next = ST_IDLE;
      end
      default: state_next = ST_RESET;
    endcase
    if (!rails_ok) begin
      state_next = ST_RESET;
      conv_next = 1'b0;
      load_next = 1'b0;
      adone_next = 1'b0;
      cnt_next = '0;
    end
  end

  // out-of-range frequency requests are ignored
  always_comb begin
    fsw_next = fsw_reg;
    if (i_fsw_wr && load_reg && i_fsw_khz >= FSW_MIN_KHZ &&
        i_fsw_khz <= FSW_MAX_KHZ)
      fsw_next = i_fsw_khz;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_RESET;
      cnt_reg <= '0;
      addr_reg <= '0;
      load_reg <= 1'b0;
      dev_reg <= BASE_ADDR_RST;
      adone_reg <= 1'b0;
      fsw_reg <= FSW_MIN_KHZ;
      conv_reg <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      load_reg <= load_next;
      dev_reg <= dev_next;
      adone_reg <= adone_next;
      fsw_reg <= fsw_next;
      conv_reg <= conv_next;
    end
  end

  // working registers: memory, no reset
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (state_reg == ST_LOAD) work_reg[addr_reg] <= i_store_data;
      else if (cfg_hit)
        work_reg[STORE_AW'(i_cfg_wr.addr - VCODE_BASE)] <=
          i_cfg_wr.data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // voltage code selection
  assign vaddr = VCODE_BASE + {5'h00, sel_q};
  logic [7:0] vcode_reg, vcode_next;
  always_comb begin
    vcode_next = load_reg ? work_reg[STORE_AW'({1'b0, sel_q})] :
                 8'h00;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) vcode_reg <= 8'h00;
    else if (i_ce) vcode_reg <= vcode_next;
  end

  assign o_por_n = (state_reg != ST_RESET);
  assign o_store_addr = addr_reg;
  assign o_load_done = load_reg;
  assign o_addr_done = adone_reg;
  assign o_dev_addr = dev_reg;
  assign o_vcode = vcode_reg;
  assign o_vcode_reg_addr = vaddr;
  assign o_fsw_khz = fsw_reg;
  assign o_cfg_wr_ack = cfg_hit;
  assign o_convert = conv_reg;

  ////////////////////////////////////////////////////////////////
  // assertions
  property p_por_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !rails_ok) |=> !o_por_n;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por left early");

  property p_conv_needs_all;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_convert |-> (o_load_done && o_addr_done && o_por_n);
  endproperty
  a_conv_needs_all: assert property (p_conv_needs_all)
    else $error("conversion without init");

  property p_conv_stop;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && o_convert && !gate_ok) |=> !o_convert;
  endproperty
  a_conv_stop: assert property (p_conv_stop)
    else $error("conversion did not stop");

  property p_pin_mode;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && i_en_mode == EN_PIN && !pin_ok) |=> !o_convert;
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("pin mode ran without pin");

  sequence s_load_start;
    i_ce && state_reg == ST_RESET && state_next == ST_LOAD;
  endsequence
  property p_load_len;
    @(posedge i_clk) disable iff (!i_arst_n)
    (s_load_start ##1 (i_ce && rails_ok) [*8]) |-> !o_load_done;
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("load finished early");

  property p_fsw_range;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_fsw_khz >= FSW_MIN_KHZ && o_fsw_khz <= FSW_MAX_KHZ;
  endproperty
  a_fsw_range: assert property (p_fsw_range)
    else $error("frequency out of range");

  property p_vaddr;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_vcode_reg_addr >= VCODE_BASE && o_vcode_reg_addr <= VCODE_LAST;
  endproperty
  a_vaddr: assert property (p_vaddr)
    else $error("code register address out of range");

  property p_dev_addr;
    @(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_addr_done) |-> (o_dev_addr >= BASE_ADDR_RST &&
      o_dev_addr <= BASE_ADDR_RST + 7'(OFFSET_MAX));
  endproperty
  a_dev_addr: assert property (p_dev_addr)
    else $error("device address below base");

  property p_cfg_ack;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_cfg_wr_ack |-> o_load_done;
  endproperty
  a_cfg_ack: assert property (p_cfg_ack)
    else $error("write taken before load");

  property p_vcode_follow;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !o_load_done) |=> (o_vcode == 8'h00);
  endproperty
  a_vcode_follow: assert property (p_vcode_follow)
    else $error("code shown before load");
endmodule

// ==== pus_env_model.sv ====
// far-side model: config store image and address strap converter
`timescale 1ns/1ps
module pus_env_model
  import pus_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_por_n,
  input wire logic [STORE_AW-1:0] i_store_addr,
  input wire logic [9:0] i_strap,
  output logic [7:0] o_store_data,
  output logic [9:0] o_adc,
  output logic o_adc_valid
);
  logic [2:0] wait_reg;
  // every entry distinct so a wrong load index shows up
  assign o_store_data = 8'hA0 + 8'(i_store_addr);
  // result not trusted before valid, so show a wrong value then
  assign o_adc = o_adc_valid ? i_strap : ~i_strap;
  assign o_adc_valid = (wait_reg == 3'h7);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_reg <= 3'h0;
    end else if (!i_por_n) begin
      wait_reg <= 3'h0;
    end else if (wait_reg != 3'h7) begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule

// ==== pus_top_test.sv ====
// self-checking bench for the power-up init sequencer
`timescale 1ns/1ps
module pus_top_test;
  import pus_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  pus_rails_type rails = 3'b000;
  logic en = 1'b0, vin = 1'b0, sw_on = 1'b0, fsw_wr = 1'b0, no_off = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [1:0] mode = EN_PIN;
  logic [10:0] fsw = 11'h000;
  pus_cfg_wr_type cw = '0;
  logic [9:0] strap = 10'h0C0;
  logic ce = 1'b1;
  logic por_n, ld, ad, ack, conv, adc_v;
  logic [3:0] sa;
  logic [7:0] sd, vc, vra;
  logic [6:0] dev;
  logic [10:0] fo;
  logic [9:0] adc;
  int fail_count = 0;
  int comparisons = 0;

  always #12.5 i_clk = ~i_clk;

  pus_top #(.SETTLE_CYC(4)) u_pus_top (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_ce(ce), .i_rails(rails), .i_enable(en), .i_vin_ok(vin),
    .i_volt_select(sel), .i_addr_adc(adc), .i_addr_adc_valid(adc_v),
    .i_store_data(sd), .i_cfg_wr(cw), .i_en_mode(mode), .i_sw_on(sw_on),
    .i_fsw_khz(fsw), .i_fsw_wr(fsw_wr), .i_no_addr_offset(no_off),
    .o_por_n(por_n), .o_store_addr(sa), .o_load_done(ld),
    .o_addr_done(ad), .o_dev_addr(dev), .o_vcode(vc),
    .o_vcode_reg_addr(vra), .o_fsw_khz(fo), .o_cfg_wr_ack(ack),
    .o_convert(conv));
  pus_env_model u_pus_env_model (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_por_n(por_n), .i_store_addr(sa), .i_strap(strap),
    .o_store_data(sd), .o_adc(adc), .o_adc_valid(adc_v));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // fixed wait past two sync stages and the gate register
  task automatic wait_conv(input logic e);
    cyc(5);
    #1 cmp(16'(conv), 16'(e));
  endtask
  task automatic wr_cfg(input logic [7:0] a, d, input logic e);
    @(posedge i_clk);
    cw <= '{1'b1, a, d};
    @(negedge i_clk);
    cmp(16'(ack), 16'(e));
    @(posedge i_clk);
    cw <= '0;
  endtask
  task automatic wr_fsw(input logic [10:0] v, e);
    @(posedge i_clk);
    fsw <= v;
    fsw_wr <= 1'b1;
    @(posedge i_clk);
    fsw_wr <= 1'b0;
    cyc(4);
    #1 cmp(16'(fo), 16'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1 cmp(16'(por_n), 16'h0000);
    cmp(16'(dev), 16'h0010);
    cmp(16'(fo), 16'(FSW_MIN_KHZ));
    cmp(16'(vra), 16'h0077);
    cmp(16'(conv), 16'h0000);
    cmp(16'(sa), 16'h0000);
  endtask
  // rails raised before enable, as the host should
  task automatic t_power_up(input logic [9:0] s, input logic [6:0] e);
    int n;
    @(posedge i_clk);
    strap <= s;
    rails <= 3'b101;
    cyc(20);
    #1 cmp(16'(por_n), 16'h0000);
    @(posedge i_clk);
    rails <= 3'b111;
    cyc(4);
    #1 cmp(16'(por_n), 16'h0000);
    wr_cfg(8'h77, 8'h11, 1'b0);
    n = 0;
    while (ad !== 1'b1 && n < 80) begin
      @(posedge i_clk);
      #1 n++;
    end
    cmp(16'(por_n), 16'h0001);
    cmp(16'(ld), 16'h0001);
    cmp(16'(dev), 16'(e));
    cmp(16'(ad), 16'h0001);
  endtask
  task automatic t_select;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      sel <= 3'(i);
      cyc(5);
      #1 cmp(16'(vra), 16'(VCODE_BASE + 8'(i)));
      cmp(16'(vc), 16'(8'hA0 + 8'(i)));
    end
  endtask
  task automatic t_cfg;
    @(posedge i_clk);
    sel <= 3'h3;
    wr_cfg(8'h7A, 8'h5C, 1'b1);
    wr_cfg(8'h76, 8'h33, 1'b0);
    wr_cfg(8'h7F, 8'h33, 1'b0);
    cyc(5);
    #1 cmp(16'(vc), 16'h005C);
  endtask
  task automatic t_fsw;
    wr_fsw(11'd149, 11'd150);
    wr_fsw(11'd1500, 11'd1500);
    wr_fsw(11'd1501, 11'd1500);
    wr_fsw(11'd150, 11'd150);
    wr_fsw(11'd600, 11'd600);
  endtask
  task automatic t_gate;
    @(posedge i_clk);
    vin <= 1'b1;
    wait_conv(1'b0);
    @(posedge i_clk);
    en <= 1'b1;
    wait_conv(1'b1);
    @(posedge i_clk);
    vin <= 1'b0;
    wait_conv(1'b0);
    @(posedge i_clk);
    vin <= 1'b1;
    wait_conv(1'b1);
    @(posedge i_clk);
    en <= 1'b0;
    wait_conv(1'b0);
  endtask
  task automatic t_modes;
    logic [4:0] tb[6];
    tb = '{{EN_ALWAYS, 3'b001}, {EN_SW_ONLY, 3'b100},
      {EN_SW_ONLY, 3'b011}, {EN_PIN_AND_SW, 3'b100},
      {EN_PIN_AND_SW, 3'b111}, {EN_PIN, 3'b010}};
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clk);
      mode <= tb[i][4:3];
      en <= tb[i][2];
      sw_on <= tb[i][1];
      wait_conv(tb[i][0]);
    end
  endtask
  // clock enable low must freeze the gate and the synchronisers
  task automatic t_hold;
    @(posedge i_clk);
    mode <= EN_ALWAYS;
    wait_conv(1'b1);
    @(posedge i_clk);
    ce <= 1'b0;
    vin <= 1'b0;
    cyc(6);
    #1 cmp(16'(conv), 16'h0001);
    @(posedge i_clk);
    ce <= 1'b1;
    wait_conv(1'b0);
    @(posedge i_clk);
    vin <= 1'b1;
    wait_conv(1'b1);
  endtask
  task automatic t_restart;
    @(posedge i_clk);
    mode <= EN_ALWAYS;
    wait_conv(1'b1);
    @(posedge i_clk);
    rails <= 3'b011;
    wait_conv(1'b0);
    cmp(16'(por_n), 16'h0000);
    cmp(16'(ld), 16'h0000);
    t_power_up(10'h3FF, 7'h1F);
    wait_conv(1'b1);
    @(posedge i_clk);
    rails <= 3'b110;
    no_off <= 1'b1;
    wait_conv(1'b0);
    cmp(16'(ad), 16'h0000);
    t_power_up(10'h3FF, 7'h10);
    wait_conv(1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 4000);
    fail_count++;
    give_verdict;
  end
  initial begin
    @(posedge i_clk);
    t_reset;
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_power_up(10'h0C0, 7'h13);
    t_select;
    t_cfg;
    t_fsw;
    t_gate;
    t_modes;
    t_hold;
    t_restart;
    give_verdict;
  end
endmodule
